// ### hw/pdgc_params.svh
/*
 * constants of the pulse/direction gated counter: register offsets, field
 * positions and reset values.
 * assumes: included by its bare name; byte addresses on a 32-bit avalon-mm bus.
 */
`ifndef PDGC_PARAMS_SVH
`define PDGC_PARAMS_SVH

`define PDGC_OFF_CTRL 5'h00
`define PDGC_OFF_PRESET 5'h04
`define PDGC_OFF_COUNT 5'h08
`define PDGC_OFF_STATUS 5'h0c
`define PDGC_OFF_MASK 5'h10

`define PDGC_CTRL_EN 0
`define PDGC_CTRL_REP 1
`define PDGC_CTRL_GEN 2
`define PDGC_CTRL_GLOW 3
`define PDGC_CTRL_RETRIG 4

`define PDGC_ST_OVF 0
`define PDGC_ST_UNF 1
`define PDGC_ST_RUN 2

`define PDGC_CTRL_RST 5'h00
`define PDGC_MASK_RST 2'h0
`define PDGC_PRESET_RST 32'h00000033

`endif

// ### hw/pdgc_pkg.sv
/*
 * types of the pulse/direction gated counter.
 * assumes: nothing beyond a systemverilog compiler.
 */
package pdgc_pkg;

    typedef enum logic [2:0] {
        PDGC_IDLE = 3'b001,
        PDGC_RUN = 3'b010,
        PDGC_HALT = 3'b100
    } pdgc_state_t;

endpackage : pdgc_pkg

// ### hw/pdgc_counter.sv
/*
 * one pulse/direction counter channel with level gate, preset reload,
 * overflow/underflow flags, interrupt and an avalon-mm register slave.
 * assumes: pulse, direction and gate arrive synchronous to core_clk_i but
 * are still passed through two flops; one avalon master with waitrequest.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdgc_params.svh"

module pdgc_counter
    import pdgc_pkg::*;
#(
    parameter int W = 32
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // link side
    input wire logic count_pulse_input_i,
    input wire logic direction_input_i,
    input wire logic gate_input_i,
    // avalon-mm slave
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    // interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] p_sync;
        logic p_prev;
        logic [1:0] d_sync;
        logic [1:0] g_sync;
        pdgc_state_t state;
        logic [W-1:0] count;
        logic [W-1:0] preset;
        logic [4:0] ctrl;
        logic [1:0] status;
        logic [1:0] mask;
        logic gate_seen;
        logic gate_spent;
        logic waitreq;
        logic [31:0] rdata;
        logic irq;
    } pdgc_regs_t;

    pdgc_regs_t q;
    pdgc_regs_t d;

    logic pulse_rise;
    logic dir_up;
    logic gate_act;
    logic gate_ok;
    logic count_ev;
    logic ovf_ev;
    logic unf_ev;
    logic wr_acc;
    logic cnt_wr;
    logic [31:0] wmask;
    logic [31:0] rd_val;

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read as zero
    always_comb begin
        case (address_i)
            `PDGC_OFF_CTRL: rd_val = {27'h0, q.ctrl};
            `PDGC_OFF_PRESET: rd_val = 32'(q.preset);
            `PDGC_OFF_COUNT: rd_val = 32'(q.count);
            `PDGC_OFF_STATUS: rd_val = {29'h0, (q.state == PDGC_RUN), q.status};
            `PDGC_OFF_MASK: rd_val = {30'h0, q.mask};
            default: rd_val = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        wmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}}, {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

        // two-flop synchronisers, edge taken only after the second flop
        d.p_sync = {q.p_sync[0], count_pulse_input_i};
        d.p_prev = q.p_sync[1];
        d.d_sync = {q.d_sync[0], direction_input_i};
        d.g_sync = {q.g_sync[0], gate_input_i};
        pulse_rise = q.p_sync[1] & ~q.p_prev;
        dir_up = q.d_sync[1];
        gate_act = q.ctrl[`PDGC_CTRL_GLOW] ? ~q.g_sync[1] : q.g_sync[1];

        // gate: disabled counts freely, otherwise only in the active level
        gate_ok = ~q.ctrl[`PDGC_CTRL_GEN]
            | (gate_act & (q.ctrl[`PDGC_CTRL_RETRIG] | ~q.gate_spent));

        count_ev = (q.state == PDGC_RUN) & q.ctrl[`PDGC_CTRL_EN] & pulse_rise & gate_ok;
        ovf_ev = count_ev & dir_up & (q.count == {W{1'b1}});
        unf_ev = count_ev & ~dir_up & (q.count == '0);

        // bus: answer one cycle after the request is seen
        wr_acc = write_i & ~q.waitreq;
        cnt_wr = wr_acc & (address_i == `PDGC_OFF_COUNT);
        d.waitreq = 1'b1;
        if ((read_i | write_i) & q.waitreq) begin
            d.waitreq = 1'b0;
            d.rdata = rd_val;
        end
        if (wr_acc) begin
            case (address_i)
                `PDGC_OFF_CTRL: d.ctrl = (q.ctrl & ~wmask[4:0]) | (writedata_i[4:0] & wmask[4:0]);
                `PDGC_OFF_PRESET: d.preset = (q.preset & ~wmask[W-1:0]) | (writedata_i[W-1:0] & wmask[W-1:0]);
                `PDGC_OFF_MASK: d.mask = (q.mask & ~wmask[1:0]) | (writedata_i[1:0] & wmask[1:0]);
                `PDGC_OFF_STATUS: d.status = q.status & ~(writedata_i[1:0] & wmask[1:0]);
                default: d.ctrl = q.ctrl;
            endcase
        end

        // counting; a software load of the count wins over a pulse in that cycle
        case (q.state)
            PDGC_IDLE: begin
                d.gate_seen = 1'b0;
                d.gate_spent = 1'b0;
                if (q.ctrl[`PDGC_CTRL_EN]) begin
                    d.state = PDGC_RUN;
                end
            end
            PDGC_RUN: begin
                if (!q.ctrl[`PDGC_CTRL_EN]) begin
                    d.state = PDGC_IDLE;
                end else begin
                    if (q.ctrl[`PDGC_CTRL_GEN] & gate_act) begin
                        d.gate_seen = 1'b1;
                    end
                    // one gated run only: leaving the active level ends it
                    if (q.ctrl[`PDGC_CTRL_GEN] & ~q.ctrl[`PDGC_CTRL_RETRIG] & q.gate_seen & ~gate_act) begin
                        d.gate_spent = 1'b1;
                    end
                    if (ovf_ev | unf_ev) begin
                        d.count = q.preset;
                        if (!q.ctrl[`PDGC_CTRL_REP]) begin
                            d.state = PDGC_HALT;
                        end
                    end else if (count_ev) begin
                        d.count = dir_up ? q.count + W'(1) : q.count - W'(1);
                    end
                end
            end
            PDGC_HALT: begin
                if (!q.ctrl[`PDGC_CTRL_EN]) begin
                    d.state = PDGC_IDLE;
                end
            end
            default: begin
                d.state = PDGC_IDLE;
            end
        endcase
        if (cnt_wr) begin
            d.count = (q.count & ~wmask[W-1:0]) | (writedata_i[W-1:0] & wmask[W-1:0]);
        end

        // sticky flags: a new event beats a clear in the same cycle
        d.status[`PDGC_ST_OVF] = d.status[`PDGC_ST_OVF] | ovf_ev;
        d.status[`PDGC_ST_UNF] = d.status[`PDGC_ST_UNF] | unf_ev;
        d.irq = |(d.status & d.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.p_sync <= 2'h0;
            q.p_prev <= 1'b0;
            q.d_sync <= 2'h0;
            q.g_sync <= 2'h0;
            q.state <= PDGC_IDLE;
            q.count <= '0;
            q.preset <= W'(`PDGC_PRESET_RST);
            q.ctrl <= `PDGC_CTRL_RST;
            q.status <= 2'h0;
            q.mask <= `PDGC_MASK_RST;
            q.gate_seen <= 1'b0;
            q.gate_spent <= 1'b0;
            q.waitreq <= 1'b1;
            q.rdata <= 32'h00000000;
            q.irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign readdata_o = q.rdata;
    assign waitrequest_o = q.waitreq;
    assign irq_o = q.irq;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_req_wait;
        (read_i | write_i) && q.waitreq;
    endsequence

    sequence s_ans;
        !q.waitreq ##1 q.waitreq;
    endsequence

    sequence s_wrap;
        (ovf_ev || unf_ev) && !wr_acc;
    endsequence

    AST_UP_ONE: assert property (
        count_ev && dir_up && !ovf_ev && !cnt_wr |=> q.count == $past(q.count) + W'(1))
        else $error("count did not rise by one");

    AST_DOWN_ONE: assert property (
        count_ev && !dir_up && !unf_ev && !cnt_wr |=> q.count == $past(q.count) - W'(1))
        else $error("count did not fall by one");

    AST_NO_COUNT_OFF: assert property (
        !q.ctrl[`PDGC_CTRL_EN] && !cnt_wr |=> q.count == $past(q.count))
        else $error("count moved while disabled");

    AST_ONCE_STOP: assert property (
        s_wrap ##0 !q.ctrl[`PDGC_CTRL_REP] |=> q.count == $past(q.preset) && q.state == PDGC_HALT ##1
            (!count_ev))
        else $error("count-once did not reload and stop");

    AST_REPEAT_GO: assert property (
        s_wrap ##0 q.ctrl[`PDGC_CTRL_REP] |=> q.count == $past(q.preset) && q.state == PDGC_RUN)
        else $error("repetitive did not reload and continue");

    AST_GATE_HIGH: assert property (
        q.ctrl[`PDGC_CTRL_GEN] && !q.ctrl[`PDGC_CTRL_GLOW] && !q.g_sync[1] |-> !count_ev)
        else $error("counted with high gate low");

    AST_GATE_LOW: assert property (
        q.ctrl[`PDGC_CTRL_GEN] && q.ctrl[`PDGC_CTRL_GLOW] && q.g_sync[1] |-> !count_ev)
        else $error("counted with low gate high");

    AST_GATE_HOLD: assert property (
        q.ctrl[`PDGC_CTRL_GEN] && !gate_act && !cnt_wr |=> $stable(q.count))
        else $error("count moved with gate inactive");

    AST_NO_RETRIG: assert property (
        q.gate_spent && !q.ctrl[`PDGC_CTRL_RETRIG] && q.ctrl[`PDGC_CTRL_GEN] |-> !count_ev)
        else $error("spent gate restarted counting");

    AST_RETRIG: assert property (
        q.state == PDGC_RUN && q.ctrl[`PDGC_CTRL_EN] && q.ctrl[`PDGC_CTRL_GEN] && q.ctrl[`PDGC_CTRL_RETRIG]
            && gate_act && pulse_rise |-> count_ev)
        else $error("retriggerable gate did not resume");

    AST_FREE: assert property (
        q.state == PDGC_RUN && q.ctrl[`PDGC_CTRL_EN] && !q.ctrl[`PDGC_CTRL_GEN] && pulse_rise |-> count_ev)
        else $error("free count missed a pulse");

    AST_FLAGS: assert property (
        ovf_ev |=> q.status[`PDGC_ST_OVF] ##1 (q.irq == (q.status[`PDGC_ST_OVF] & q.mask[`PDGC_ST_OVF])
            || q.status[`PDGC_ST_UNF]))
        else $error("overflow flag or interrupt missing");

    AST_EDGE: assert property (
        pulse_rise |-> $past(q.p_sync[0]) && !q.p_prev)
        else $error("pulse edge not from synchroniser");

    AST_BUS: assert property (
        s_req_wait |=> s_ans)
        else $error("bus answer not after one cycle");

    AST_ANS_ONE: assert property (
        !q.waitreq |=> q.waitreq)
        else $error("waitrequest low for more than one cycle");

    AST_NO_ANS: assert property (
        q.waitreq && !read_i && !write_i |=> q.waitreq)
        else $error("answer without a request");

    AST_RD_HOLD: assert property (
        !((read_i || write_i) && q.waitreq) |=> $stable(q.rdata))
        else $error("read data moved without a request");

    AST_RD_COUNT: assert property (
        read_i && q.waitreq && address_i == `PDGC_OFF_COUNT |=> q.rdata == $past(32'(q.count)))
        else $error("count read returned a wrong value");

    AST_CNT_LOAD: assert property (
        cnt_wr && byteenable_i == 4'hf |=> q.count == $past(writedata_i[W-1:0]))
        else $error("count write did not load");

    AST_MASK_WR: assert property (
        wr_acc && address_i == `PDGC_OFF_MASK && byteenable_i[0] |=> q.mask == $past(writedata_i[1:0]))
        else $error("mask write did not land");

    AST_QUIET: assert property (
        !count_ev && !cnt_wr |=> $stable(q.count))
        else $error("count moved without a pulse");

    AST_ENTER_RUN: assert property (
        q.state == PDGC_IDLE && q.ctrl[`PDGC_CTRL_EN] |=> q.state == PDGC_RUN)
        else $error("enable did not start the channel");

    AST_LEAVE: assert property (
        q.state != PDGC_IDLE && !q.ctrl[`PDGC_CTRL_EN] |=> q.state == PDGC_IDLE)
        else $error("clearing enable did not stop the channel");

    AST_HALT_STAY: assert property (
        q.state == PDGC_HALT && q.ctrl[`PDGC_CTRL_EN] |=> q.state == PDGC_HALT)
        else $error("count-once left the halt while enabled");

    AST_HALT_HOLD: assert property (
        q.state == PDGC_HALT && !cnt_wr |=> $stable(q.count))
        else $error("count moved while halted");

    AST_SPENT_KEEP: assert property (
        q.gate_spent && q.state == PDGC_RUN && q.ctrl[`PDGC_CTRL_EN] |=> q.gate_spent)
        else $error("spent gate re-armed while running");

    AST_RETRIG_FRESH: assert property (
        q.ctrl[`PDGC_CTRL_RETRIG] && !q.gate_spent && q.state == PDGC_RUN |=> !q.gate_spent)
        else $error("retriggerable gate marked spent");

    AST_UNF_FLAG: assert property (
        unf_ev |=> q.status[`PDGC_ST_UNF])
        else $error("underflow flag missing");

    AST_FLAG_CLEAR: assert property (
        wr_acc && address_i == `PDGC_OFF_STATUS && writedata_i[0] && byteenable_i[0] && !ovf_ev
            |=> !q.status[`PDGC_ST_OVF])
        else $error("overflow flag not cleared");

    AST_FLAG_STICKY: assert property (
        q.status[`PDGC_ST_OVF] && !wr_acc |=> q.status[`PDGC_ST_OVF])
        else $error("overflow flag dropped by itself");

    AST_IRQ_LEVEL: assert property (
        q.irq == (|(q.status & q.mask)))
        else $error("interrupt level does not follow status and mask");

endmodule : pdgc_counter
`default_nettype wire

// ### bench/pdgc_pulse_src.sv
/*
 * field-side source of pulse, direction and gate levels for the counter.
 * assumes: shares core_clk_i with the counter; the bench calls its tasks.
 */
`timescale 1ns/1ps
`default_nettype none

module pdgc_pulse_src (
    // clock
    input wire logic core_clk_i,
    // field lines
    output logic count_pulse_input_o,
    output logic direction_input_o,
    output logic gate_input_o
);
    ////////////////////////////////////////
    initial begin
        count_pulse_input_o = 1'b0;
        direction_input_o = 1'b0;
        gate_input_o = 1'b0;
    end
    // direction set a cycle ahead so the sync flops carry it with the rise
    task automatic pulse(input logic up);
        @(posedge core_clk_i);
        direction_input_o <= up;
        @(posedge core_clk_i);
        count_pulse_input_o <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        count_pulse_input_o <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask : pulse
    task automatic gate(input logic lvl);
        @(posedge core_clk_i);
        gate_input_o <= lvl;
        repeat (3) @(posedge core_clk_i);
    endtask : gate
endmodule : pdgc_pulse_src

`default_nettype wire

// ### bench/tb_pdgc_counter.sv
/*
 * self-checking bench of the pulse/direction gated counter.
 * assumes: pdgc_params.svh on the include path; pdgc_pulse_src compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdgc_params.svh"

module tb_pdgc_counter;
    typedef struct packed {
        logic [4:0] ctrl;
        logic gate;
        logic up;
        logic [3:0] n;
        logic [31:0] exp;
    } pdgc_row_t;
    logic core_clk;
    logic rst;
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [3:0] be_nxt;
    logic pls, dirl, gatel, wreq, irq;
    logic [31:0] rdata, val;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    pdgc_row_t rows [8] = '{
        '{5'h01, 1'b0, 1'b1, 4'd3, 32'h36},
        '{5'h01, 1'b1, 1'b0, 4'd2, 32'h31},
        '{5'h00, 1'b0, 1'b1, 4'd2, 32'h33},
        '{5'h05, 1'b1, 1'b1, 4'd2, 32'h35},
        '{5'h05, 1'b0, 1'b1, 4'd2, 32'h33},
        '{5'h0d, 1'b0, 1'b0, 4'd2, 32'h31},
        '{5'h0d, 1'b1, 1'b1, 4'd2, 32'h33},
        '{5'h1f, 1'b0, 1'b0, 4'd1, 32'h32}};
    ////////////////////////////////////////
    pdgc_counter u_pdgc_counter (.core_clk_i(core_clk), .rst_i(rst),
        .count_pulse_input_i(pls), .direction_input_i(dirl), .gate_input_i(gatel),
        .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdata),
        .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wreq), .irq_o(irq));
    pdgc_pulse_src u_pdgc_pulse_src (.core_clk_i(core_clk), .count_pulse_input_o(pls),
        .direction_input_o(dirl), .gate_input_o(gatel));
    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic tally_and_finish;
        if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // a hung handshake ends the run as a failure
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        be <= be_nxt;
        wdata <= d;
        wr <= we;
        rd <= !we;
        do @(posedge core_clk); while (wreq !== 1'b0);
        val = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(val, exp);
    endtask : rdc
    task automatic irq_is(input logic exp);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_is
    ////////////////////////////////////////
    initial begin
        rst <= 1'b1;
        rd <= 1'b0;
        wr <= 1'b0;
        addr <= 5'h00;
        wdata <= 32'h0;
        be <= 4'hf;
        be_nxt = 4'hf;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rdc(`PDGC_OFF_CTRL, 32'h0);
        rdc(`PDGC_OFF_PRESET, 32'h33);
        rdc(`PDGC_OFF_COUNT, 32'h0);
        rdc(`PDGC_OFF_STATUS, 32'h0);
        rdc(`PDGC_OFF_MASK, 32'h0);
        bus(1'b1, 5'h14, 32'h5a);
        rdc(5'h14, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, `PDGC_OFF_CTRL, 32'h0);
            u_pdgc_pulse_src.gate(rows[i].gate);
            bus(1'b1, `PDGC_OFF_COUNT, 32'h33);
            bus(1'b1, `PDGC_OFF_CTRL, {27'h0, rows[i].ctrl});
            repeat (rows[i].n) u_pdgc_pulse_src.pulse(rows[i].up);
            rdc(`PDGC_OFF_COUNT, rows[i].exp);
        end
        // overflow in count-once mode stops at the preset
        bus(1'b1, `PDGC_OFF_CTRL, 32'h0);
        bus(1'b1, `PDGC_OFF_MASK, 32'h1);
        bus(1'b1, `PDGC_OFF_COUNT, 32'hffffffff);
        bus(1'b1, `PDGC_OFF_CTRL, 32'h1);
        u_pdgc_pulse_src.pulse(1'b1);
        rdc(`PDGC_OFF_COUNT, 32'h33);
        irq_is(1'b1);
        u_pdgc_pulse_src.pulse(1'b1);
        rdc(`PDGC_OFF_COUNT, 32'h33);
        bus(1'b0, `PDGC_OFF_STATUS, 32'h0);
        chk(val, 32'h1);
        bus(1'b1, `PDGC_OFF_STATUS, 32'h1);
        irq_is(1'b0);
        // underflow in repetitive mode keeps counting from the preset
        bus(1'b1, `PDGC_OFF_CTRL, 32'h0);
        bus(1'b1, `PDGC_OFF_PRESET, 32'h40);
        bus(1'b1, `PDGC_OFF_COUNT, 32'h0);
        bus(1'b1, `PDGC_OFF_CTRL, 32'h3);
        u_pdgc_pulse_src.pulse(1'b0);
        rdc(`PDGC_OFF_COUNT, 32'h40);
        irq_is(1'b0);
        u_pdgc_pulse_src.pulse(1'b0);
        rdc(`PDGC_OFF_COUNT, 32'h3f);
        bus(1'b0, `PDGC_OFF_STATUS, 32'h0);
        chk(val, 32'h6);
        bus(1'b1, `PDGC_OFF_MASK, 32'h3);
        irq_is(1'b1);
        bus(1'b1, `PDGC_OFF_STATUS, 32'h2);
        irq_is(1'b0);
        // gate leaves and returns: only the retriggerable setting resumes
        for (int r = 0; r < 2; r++) begin
            bus(1'b1, `PDGC_OFF_CTRL, 32'h0);
            u_pdgc_pulse_src.gate(1'b1);
            bus(1'b1, `PDGC_OFF_COUNT, 32'h33);
            bus(1'b1, `PDGC_OFF_CTRL, (r == 1) ? 32'h15 : 32'h05);
            u_pdgc_pulse_src.pulse(1'b1);
            u_pdgc_pulse_src.gate(1'b0);
            u_pdgc_pulse_src.pulse(1'b1);
            u_pdgc_pulse_src.gate(1'b1);
            u_pdgc_pulse_src.pulse(1'b1);
            rdc(`PDGC_OFF_COUNT, (r == 1) ? 32'h35 : 32'h34);
        end
        // second reset in mid-run
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(rdata, 32'h0);
        chk({31'h0, wreq}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rst <= 1'b0;
        rdc(`PDGC_OFF_COUNT, 32'h0);
        rdc(`PDGC_OFF_PRESET, 32'h33);
        rdc(`PDGC_OFF_CTRL, 32'h0);
        rdc(`PDGC_OFF_STATUS, 32'h0);
        // only the lane with its enable set is written
        be_nxt = 4'h2;
        bus(1'b1, `PDGC_OFF_COUNT, 32'h12345678);
        be_nxt = 4'hf;
        rdc(`PDGC_OFF_COUNT, 32'h00005600);
        tally_and_finish();
    end
endmodule : tb_pdgc_counter

`default_nettype wire
